// ---- rtl/php_pkg.sv ----
// php_pkg: constants shared by the parallel host bus port
package php_pkg;
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int BANKS = 6;
	localparam int SYNC_STAGES = 3;
	// positions of the host pins inside the synchroniser vector
	localparam int PIN_ADDR_LSB = 0;
	localparam int PIN_DATA_LSB = 8;
	localparam int PIN_SELECT = 24;
	localparam int PIN_STROBE = 25;
	localparam int PIN_DIR = 26;
	localparam int PIN_LATCH = 27;
	localparam int PIN_BYTE_EN = 28;
	localparam int PIN_WIDTH = 29;
	localparam int PIN_PROTO = 30;
	localparam int PIN_W = 31;
	// all host pins carry pull-ups, so the synchronisers start high
	localparam logic PIN_RST = 1'b1;
	// register map (byte addresses)
	localparam logic [7:0] STATUS_BASE = 8'h00;
	localparam logic [7:0] MASK_BASE = 8'h08;
	localparam logic [7:0] SUMMARY_ADDR = 8'h10;
	localparam logic [7:0] PIN_CFG_ADDR = 8'h11;
	localparam logic [7:0] UNMAPPED_VAL = 8'h00;
	// reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hff;
	localparam logic [1:0] PIN_CFG_RST = 2'h0;
	// interrupt pin configuration field and encodings
	localparam int PIN_CFG_LSB = 0;
	localparam int PIN_CFG_W = 2;
	localparam logic [1:0] IRQ_OPEN_DRAIN = 2'h0;
	localparam logic [1:0] IRQ_PP_LOW = 2'h1;
	localparam logic [1:0] IRQ_PP_HIGH = 2'h3;
	// strap levels
	localparam logic NARROW_BUS_SETTING = 1'b0;
	localparam logic WIDE_BUS_SETTING = 1'b1;
	localparam logic SPLIT_STROBE_PROTOCOL = 1'b0;
	localparam logic STROBE_DIR_PROTOCOL = 1'b1;
endpackage : php_pkg

// ---- rtl/php_port.sv ----
// php_port: parallel host bus port with interrupt status, mask and pin driver
module php_port #(
	parameter int BANKS = php_pkg::BANKS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] addr_pin,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic [15:0] data_oe,
	output logic [15:0] data_pullup,
	input wire logic select_b,
	input wire logic access_strobe_b,
	input wire logic dir_pin,
	input wire logic addr_latch,
	input wire logic byte_enable_b,
	input wire logic bus_width_strap,
	input wire logic bus_protocol_strap,
	input wire logic [8*BANKS-1:0] irq_src,
	output logic irq_out,
	output logic irq_oe
);
	localparam int BW = php_pkg::BYTE_W;

	// the map has room for exactly the documented six banks
	if (BANKS != php_pkg::BANKS)
	begin : g_bad_banks
		$error("php_port: BANKS must equal six");
	end

	////////////////////////////////////////////////////////////////////////
	// reset release through two flip-flops
	logic rst_s1_r;
	logic rst_sync_b;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_s1_r <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_sync_b <= rst_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host pins: three stages, accepted once stages two and three agree
	logic [php_pkg::PIN_W-1:0] pin_raw;
	logic [php_pkg::PIN_W-1:0] pin_f;
	assign pin_raw = {bus_protocol_strap, bus_width_strap, byte_enable_b, addr_latch,
		dir_pin, access_strobe_b, select_b, data_in, addr_pin};
	for (genvar g = 0; g < php_pkg::PIN_W; g++)
	begin : g_sync
		logic s1_r;
		logic s2_r;
		logic s3_r;
		always_ff @(posedge clk or negedge rst_sync_b)
		begin
			if (!rst_sync_b)
			begin
				s1_r <= php_pkg::PIN_RST;
				s2_r <= php_pkg::PIN_RST;
				s3_r <= php_pkg::PIN_RST;
				pin_f[g] <= php_pkg::PIN_RST;
			end
			else
			begin
				s1_r <= pin_raw[g];
				s2_r <= s1_r;
				s3_r <= s2_r;
				if (s2_r == s3_r)
					pin_f[g] <= s2_r;
			end
		end
	end

	logic [7:0] addr_f;
	logic [15:0] data_f;
	logic wide;
	logic moto;
	logic ale_f;
	assign addr_f = pin_f[php_pkg::PIN_ADDR_LSB +: 8];
	assign data_f = pin_f[php_pkg::PIN_DATA_LSB +: 16];
	assign ale_f = pin_f[php_pkg::PIN_LATCH];
	assign wide = (pin_f[php_pkg::PIN_WIDTH] == php_pkg::WIDE_BUS_SETTING);
	assign moto = (pin_f[php_pkg::PIN_PROTO] == php_pkg::STROBE_DIR_PROTOCOL);

	////////////////////////////////////////////////////////////////////////
	// address latch: live address while the strobe is high, held after it falls
	logic ale_d_r;
	logic [7:0] addr_lat_r;
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			ale_d_r <= 1'b1;
			addr_lat_r <= 8'h00;
		end
		else
		begin
			ale_d_r <= ale_f;
			if (ale_d_r && !ale_f)
				addr_lat_r <= addr_f;
		end
	end
	// a strobe tied high never falls, so demultiplexed buses use the live pins
	logic [7:0] addr_eff;
	assign addr_eff = ale_f ? addr_f : addr_lat_r;

	////////////////////////////////////////////////////////////////////////
	// access decode; reads also need the direction pin high so a split-strobe
	// host that glitches both strobes low never gets read and write at once
	logic selected;
	logic strobe_on;
	logic read_act;
	logic write_act;
	assign selected = !pin_f[php_pkg::PIN_SELECT];
	assign strobe_on = !pin_f[php_pkg::PIN_STROBE];
	assign read_act = selected && strobe_on && pin_f[php_pkg::PIN_DIR];
	assign write_act = moto ? (selected && strobe_on && !pin_f[php_pkg::PIN_DIR])
		: (selected && !strobe_on && !pin_f[php_pkg::PIN_DIR]);

	////////////////////////////////////////////////////////////////////////
	// lane selection: even and odd byte of the addressed pair
	logic addr_bit_zero;
	logic [6:0] pair;
	logic upper_byte_enable;
	logic lower_byte_enable;
	logic even_en;
	logic odd_en;
	logic even_hi;
	logic odd_hi;
	assign addr_bit_zero = addr_eff[0];
	assign pair = addr_eff[7:1];
	assign upper_byte_enable = !pin_f[php_pkg::PIN_BYTE_EN];
	assign lower_byte_enable = !pin_f[php_pkg::PIN_BYTE_EN];
	assign even_en = !addr_bit_zero;
	// narrow bus takes the addressed byte alone, the enable pin plays no part
	assign odd_en = !wide ? addr_bit_zero
		: (moto ? lower_byte_enable : upper_byte_enable);
	assign even_hi = wide && moto;
	assign odd_hi = wide && !moto;

	////////////////////////////////////////////////////////////////////////
	// register storage
	logic [8*BANKS-1:0] irq_status_bank_r;
	logic [8*BANKS-1:0] irq_mask_bank_r;
	logic [1:0] irq_pin_config_r;
	logic [7:0] global_irq_summary;

	function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [8*BANKS-1:0] st,
		input logic [8*BANKS-1:0] mk, input logic [7:0] sum, input logic [1:0] cfg);
		logic [7:0] r;
		r = php_pkg::UNMAPPED_VAL;
		for (int i = 0; i < BANKS; i++)
		begin
			if (a == 8'(php_pkg::STATUS_BASE + i))
				r = st[i*8 +: 8];
			if (a == 8'(php_pkg::MASK_BASE + i))
				r = mk[i*8 +: 8];
		end
		if (a == php_pkg::SUMMARY_ADDR)
			r = sum;
		if (a == php_pkg::PIN_CFG_ADDR)
			r = {6'h00, cfg};
		return r;
	endfunction : rd_byte

	// read path: on a wide bus split strobes put even on the low lane, direction strobe the high lane; a narrow bus uses the low lane
	logic [7:0] rd_even;
	logic [7:0] rd_odd;
	logic [7:0] rd_lo;
	logic [7:0] rd_hi;
	logic lo_used;
	logic hi_used;
	logic [15:0] oe_nxt;
	assign rd_even = rd_byte({pair, 1'b0}, irq_status_bank_r, irq_mask_bank_r,
		global_irq_summary, irq_pin_config_r);
	assign rd_odd = rd_byte({pair, 1'b1}, irq_status_bank_r, irq_mask_bank_r,
		global_irq_summary, irq_pin_config_r);
	assign rd_lo = ((wide && moto) || (!wide && addr_bit_zero)) ? rd_odd : rd_even;
	assign rd_hi = moto ? rd_even : rd_odd;
	assign lo_used = !wide || (moto ? odd_en : even_en);
	assign hi_used = wide && (moto ? even_en : odd_en);
	// drivers stay off unless this is a selected read
	assign oe_nxt = {{8{read_act && hi_used}}, {8{read_act && lo_used}}};

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			data_out <= 16'h0000;
			data_oe <= 16'h0000;
			data_pullup <= 16'hffff;
		end
		else
		begin
			data_out <= {rd_hi, rd_lo};
			data_oe <= oe_nxt;
			data_pullup <= ~oe_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write path: data is sampled through the strobe, committed as it ends,
	// because the host only guarantees stable data by the trailing edge
	logic wr_act_d_r;
	logic [6:0] wpair_r;
	logic wev_en_r;
	logic wod_en_r;
	logic [7:0] wev_d_r;
	logic [7:0] wod_d_r;
	logic commit;
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			wr_act_d_r <= 1'b0;
			wpair_r <= 7'h00;
			wev_en_r <= 1'b0;
			wod_en_r <= 1'b0;
			wev_d_r <= 8'h00;
			wod_d_r <= 8'h00;
		end
		else
		begin
			wr_act_d_r <= write_act;
			if (write_act)
			begin
				wpair_r <= pair;
				wev_en_r <= even_en;
				wod_en_r <= odd_en;
				wev_d_r <= even_hi ? data_f[15:8] : data_f[7:0];
				wod_d_r <= odd_hi ? data_f[15:8] : data_f[7:0];
			end
		end
	end
	assign commit = wr_act_d_r && !write_act;

	////////////////////////////////////////////////////////////////////////
	// status banks are write-one-to-clear; a new event beats a clear
	logic [BANKS-1:0] bank_pend;
	for (genvar i = 0; i < BANKS; i++)
	begin : g_bank
		localparam logic [7:0] SA = 8'(php_pkg::STATUS_BASE + i);
		localparam logic [7:0] MA = 8'(php_pkg::MASK_BASE + i);
		logic st_we;
		logic mk_we;
		logic [7:0] clr;
		assign st_we = commit && (SA[0] ? wod_en_r : wev_en_r) && (wpair_r == SA[7:1]);
		assign mk_we = commit && (MA[0] ? wod_en_r : wev_en_r) && (wpair_r == MA[7:1]);
		assign clr = st_we ? (SA[0] ? wod_d_r : wev_d_r) : 8'h00;
		always_ff @(posedge clk or negedge rst_sync_b)
		begin
			if (!rst_sync_b)
			begin
				irq_status_bank_r[i*8 +: 8] <= php_pkg::STATUS_RST;
				irq_mask_bank_r[i*8 +: 8] <= php_pkg::MASK_RST;
			end
			else
			begin
				irq_status_bank_r[i*8 +: 8] <= (irq_status_bank_r[i*8 +: 8] & ~clr)
					| irq_src[i*8 +: 8];
				if (mk_we)
					irq_mask_bank_r[i*8 +: 8] <= MA[0] ? wod_d_r : wev_d_r;
			end
		end
		// a set mask bit blocks its source
		assign bank_pend[i] = |(irq_status_bank_r[i*8 +: 8] & ~irq_mask_bank_r[i*8 +: 8]);
	end
	assign global_irq_summary = {2'b00, bank_pend};

	// pin configuration register
	logic cfg_we;
	assign cfg_we = commit && (php_pkg::PIN_CFG_ADDR[0] ? wod_en_r : wev_en_r)
		&& (wpair_r == php_pkg::PIN_CFG_ADDR[7:1]);
	logic [7:0] cfg_wd;
	assign cfg_wd = php_pkg::PIN_CFG_ADDR[0] ? wod_d_r : wev_d_r;

	////////////////////////////////////////////////////////////////////////
	// interrupt pin driver
	logic pending;
	logic irq_out_nxt;
	logic irq_oe_nxt;
	assign pending = |bank_pend;
	assign irq_out_nxt = (irq_pin_config_r == php_pkg::IRQ_PP_HIGH) ? pending
		: ((irq_pin_config_r == php_pkg::IRQ_PP_LOW) ? !pending : 1'b0);
	// open drain only pulls low; the undefined code 2 also behaves as open drain
	assign irq_oe_nxt = (irq_pin_config_r == php_pkg::IRQ_PP_HIGH)
		|| (irq_pin_config_r == php_pkg::IRQ_PP_LOW) || pending;
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			irq_pin_config_r <= php_pkg::PIN_CFG_RST;
			irq_out <= 1'b0;
			irq_oe <= 1'b0;
		end
		else
		begin
			if (cfg_we)
				irq_pin_config_r <= cfg_wd[php_pkg::PIN_CFG_LSB +: php_pkg::PIN_CFG_W];
			irq_out <= irq_out_nxt;
			irq_oe <= irq_oe_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	logic irq_asserted;
	assign irq_asserted = (irq_pin_config_r == php_pkg::IRQ_PP_HIGH) ? irq_out
		: (irq_oe && !irq_out);

	sequence s_write_end;
		write_act ##1 !write_act;
	endsequence
	sequence s_latch_fall;
		ale_f ##1 !ale_f;
	endsequence

	a_write_commit: assert property (@(posedge clk) disable iff (!rst_sync_b)
		s_write_end |-> commit)
		else $error("write strobe end did not commit");
	a_cfg_loaded: assert property (@(posedge clk) disable iff (!rst_sync_b)
		cfg_we |=> irq_pin_config_r == $past(cfg_wd[1:0]))
		else $error("pin configuration not loaded");
	a_latch_addr: assert property (@(posedge clk) disable iff (!rst_sync_b)
		s_latch_fall |=> addr_lat_r == $past(addr_f))
		else $error("address not captured on latch fall");
	a_narrow_upper: assert property (@(posedge clk) disable iff (!rst_sync_b)
		!wide |=> (data_oe[15:8] == 8'h00) && (data_pullup[15:8] == 8'hff))
		else $error("upper lane used on narrow bus");
	a_no_idle_drive: assert property (@(posedge clk) disable iff (!rst_sync_b)
		!read_act |=> data_oe == 16'h0000)
		else $error("data driven outside a selected read");
	a_word_read: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(read_act && wide && even_en && odd_en) |=> data_oe == 16'hffff)
		else $error("word read did not drive all lines");
	a_split_upper: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(wide && !moto && read_act && addr_bit_zero && upper_byte_enable)
		|=> data_oe == 16'hff00)
		else $error("odd byte not on upper lane");
	a_dir_lower: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(wide && moto && read_act && addr_bit_zero && lower_byte_enable)
		|=> data_oe == 16'h00ff)
		else $error("odd byte not on lower lane");
	a_enable_ignored: assert property (@(posedge clk) disable iff (!rst_sync_b)
		!wide |-> (odd_en == addr_bit_zero) && (even_en == !addr_bit_zero))
		else $error("byte enable used on narrow bus");
	a_deselect_quiet: assert property (@(posedge clk) disable iff (!rst_sync_b)
		!selected |-> !read_act && !write_act)
		else $error("access taken while deselected");
	a_dir_protocol: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(moto && selected && strobe_on) |-> (read_act == pin_f[php_pkg::PIN_DIR])
		&& (write_act == !pin_f[php_pkg::PIN_DIR]))
		else $error("direction line not followed");
	a_event_kept: assert property (@(posedge clk) disable iff (!rst_sync_b)
		1'b1 |=> (irq_status_bank_r & $past(irq_src)) == $past(irq_src))
		else $error("interrupt event lost");
	a_irq_follows: assert property (@(posedge clk) disable iff (!rst_sync_b)
		$stable(irq_pin_config_r) |-> (irq_asserted == $past(pending)))
		else $error("interrupt pin does not follow pending status");
endmodule : php_port

// ---- verification/php_host_model.sv ----
// php_host_model: host processor model that drives the parallel port pins
module php_host_model (
	input wire logic clk,
	input wire logic bus_protocol_strap,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe,
	input wire logic [15:0] data_pullup,
	output logic [15:0] data_in,
	output logic [7:0] addr_pin,
	output logic select_b,
	output logic access_strobe_b,
	output logic dir_pin,
	output logic addr_latch,
	output logic byte_enable_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] host_d;
	logic host_oe;

	////////////////////////////////////////////////////////////////////////////////
	// wire level: device drive wins, then host, then pull-up; a floating line shows
	// the inverse of the device value so a stale level never passes for data
	always_comb
	begin
		for (int i = 0; i < 16; i++)
			data_in[i] = data_oe[i] ? data_out[i] : host_oe ? host_d[i] :
				data_pullup[i] ? 1'b1 : ~data_out[i];
	end

	// idle bus: every strobe and select released, as the pull-ups would leave it
	initial
	begin
		addr_pin = 8'h00;
		select_b = 1'b1;
		access_strobe_b = 1'b1;
		dir_pin = 1'b1;
		addr_latch = 1'b1;
		byte_enable_b = 1'b1;
		host_d = 16'h0000;
		host_oe = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one bus cycle; pins held 7 clocks so the filtered copy inside settles
	task automatic access(input logic wr, input logic [7:0] a, input logic en_b,
		input logic [15:0] wd, input logic sel_b, output logic [15:0] rd,
		output logic [15:0] oe_mid, output logic [15:0] oe_end);
		@(negedge clk);
		addr_pin = a;
		byte_enable_b = en_b;
		select_b = sel_b;
		host_d = wd;
		host_oe = wr;
		if (bus_protocol_strap)
		begin
			access_strobe_b = 1'b0;
			dir_pin = !wr;
		end
		else if (wr)
			dir_pin = 1'b0;
		else
			access_strobe_b = 1'b0;
		repeat (7) @(negedge clk);
		rd = data_in;
		oe_mid = data_oe;
		// strobe ends first, data and select stay until the write has committed
		access_strobe_b = 1'b1;
		if (!bus_protocol_strap)
			dir_pin = 1'b1;
		repeat (7) @(negedge clk);
		oe_end = data_oe;
		select_b = 1'b1;
		host_oe = 1'b0;
		dir_pin = 1'b1;
		repeat (2) @(negedge clk);
	endtask : access

	// address latch strobe for a multiplexed bus
	task automatic set_latch(input logic lv, input logic [7:0] a);
		@(negedge clk);
		addr_pin = a;
		addr_latch = lv;
		repeat (7) @(negedge clk);
	endtask : set_latch
endmodule : php_host_model

// ---- verification/tb_php_port.sv ----
// tb_php_port: self-checking bench for the parallel host bus port
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR at %0t: got %h expected %h", $time, g, e); end end
module tb_php_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic bus_width_strap = 1'b0;
	logic bus_protocol_strap = 1'b0;
	logic [47:0] irq_src = 48'h0;
	logic [7:0] addr_pin;
	logic [15:0] data_in, data_out, data_oe, data_pullup, rd, om, oe_end;
	logic select_b, access_strobe_b, dir_pin, addr_latch, byte_enable_b, irq_out, irq_oe;
	int n_errors = 0;
	int samples_checked = 0;

	////////////////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	always #5 clk = ~clk;

	php_port php_port_i (.clk(clk), .rst_b(rst_b), .addr_pin(addr_pin), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .data_pullup(data_pullup),
		.select_b(select_b), .access_strobe_b(access_strobe_b), .dir_pin(dir_pin),
		.addr_latch(addr_latch), .byte_enable_b(byte_enable_b),
		.bus_width_strap(bus_width_strap), .bus_protocol_strap(bus_protocol_strap),
		.irq_src(irq_src), .irq_out(irq_out), .irq_oe(irq_oe));

	php_host_model php_host_model_i (.clk(clk), .bus_protocol_strap(bus_protocol_strap),
		.data_out(data_out), .data_oe(data_oe), .data_pullup(data_pullup),
		.data_in(data_in), .addr_pin(addr_pin), .select_b(select_b),
		.access_strobe_b(access_strobe_b), .dir_pin(dir_pin), .addr_latch(addr_latch),
		.byte_enable_b(byte_enable_b));

	////////////////////////////////////////////////////////////////////////////////
	// bus helpers; every read also checks the lines are released afterwards
	task automatic wr(input logic [7:0] a, input logic en_b, input logic [15:0] d);
		php_host_model_i.access(1'b1, a, en_b, d, 1'b0, rd, om, oe_end);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic en_b, input logic [15:0] exp,
		input logic [15:0] exp_oe);
		php_host_model_i.access(1'b0, a, en_b, 16'h0000, 1'b0, rd, om, oe_end);
		`CHK(rd, exp)
		`CHK(om, exp_oe)
		`CHK(oe_end, 16'h0000)
	endtask : rd_chk

	// straps pass synchronisers, so give them time to land
	task automatic mode(input logic w, input logic p);
		@(negedge clk);
		bus_width_strap = w;
		bus_protocol_strap = p;
		repeat (8) @(negedge clk);
	endtask : mode

	task automatic irq_chk(input logic oe, input logic o);
		`CHK(irq_oe, oe)
		`CHK(irq_out, o)
	endtask : irq_chk

	task automatic pulse_src(input logic [47:0] s);
		@(negedge clk);
		irq_src = s;
		@(negedge clk);
		irq_src = 48'h0;
		repeat (4) @(negedge clk);
	endtask : pulse_src

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs well under 3000 clocks
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		finish_test();
	end

	// main sequence
	initial
	begin
		repeat (5) @(negedge clk);
		`CHK(data_oe, 16'h0000)
		`CHK(data_pullup, 16'hffff)
		rst_b = 1'b1;
		repeat (10) @(negedge clk);
		irq_chk(1'b0, 1'b0);
		// narrow bus, split strobes
		rd_chk(8'h08, 1'b1, 16'hffff, 16'h00ff);
		wr(8'h08, 1'b1, 16'h005a);
		rd_chk(8'h08, 1'b1, 16'hff5a, 16'h00ff);
		rd_chk(8'h08, 1'b0, 16'hff5a, 16'h00ff);
		php_host_model_i.access(1'b1, 8'h08, 1'b1, 16'h0011, 1'b1, rd, om, oe_end);
		php_host_model_i.access(1'b0, 8'h08, 1'b1, 16'h0000, 1'b1, rd, om, oe_end);
		`CHK(om, 16'h0000)
		rd_chk(8'h08, 1'b1, 16'hff5a, 16'h00ff);
		rd_chk(8'h20, 1'b1, 16'hff00, 16'h00ff);
		wr(8'h10, 1'b1, 16'h00ff);
		rd_chk(8'h10, 1'b1, 16'hff00, 16'h00ff);
		$display("narrow split test done");
		// wide bus, split strobes
		mode(1'b1, 1'b0);
		wr(8'h08, 1'b0, 16'h3ca5);
		rd_chk(8'h08, 1'b0, 16'h3ca5, 16'hffff);
		rd_chk(8'h08, 1'b1, 16'hffa5, 16'h00ff);
		rd_chk(8'h09, 1'b0, 16'h3cff, 16'hff00);
		wr(8'h09, 1'b0, 16'h7700);
		rd_chk(8'h08, 1'b0, 16'h77a5, 16'hffff);
		$display("wide split test done");
		// wide bus, data strobe plus direction line
		mode(1'b1, 1'b1);
		rd_chk(8'h08, 1'b0, 16'ha577, 16'hffff);
		rd_chk(8'h09, 1'b0, 16'hff77, 16'h00ff);
		wr(8'h08, 1'b1, 16'h1200);
		rd_chk(8'h08, 1'b0, 16'h1277, 16'hffff);
		php_host_model_i.set_latch(1'b1, 8'h08);
		php_host_model_i.set_latch(1'b0, 8'h08);
		rd_chk(8'h55, 1'b0, 16'h1277, 16'hffff);
		php_host_model_i.set_latch(1'b1, 8'h00);
		$display("wide direction test done");
		// interrupt: unmask bank 0 bit 0, then walk the pin styles
		wr(8'h08, 1'b0, 16'hfeff);
		pulse_src(48'h000000000100);
		irq_chk(1'b0, 1'b0);
		pulse_src(48'h000000000001);
		irq_chk(1'b1, 1'b0);
		rd_chk(8'h10, 1'b1, 16'h01ff, 16'hff00);
		rd_chk(8'h00, 1'b1, 16'h01ff, 16'hff00);
		wr(8'h11, 1'b0, 16'h0003);
		irq_chk(1'b1, 1'b1);
		wr(8'h11, 1'b0, 16'h0001);
		irq_chk(1'b1, 1'b0);
		wr(8'h00, 1'b1, 16'h0100);
		irq_chk(1'b1, 1'b1);
		wr(8'h11, 1'b0, 16'h0003);
		irq_chk(1'b1, 1'b0);
		wr(8'h11, 1'b0, 16'h0002);
		irq_chk(1'b0, 1'b0);
		rd_chk(8'h10, 1'b1, 16'h00ff, 16'hff00);
		$display("interrupt test done");
		finish_test();
	end
endmodule : tb_php_port
